// >>> design/rfcm_pkg.sv
/*
 * Package for the fault countdown and misc syndrome register block.
 * Assumes a single 20 MHz clock and a system-register access port.
 */
package rfcm_pkg;
	localparam logic [1:0] LVL_ZERO = 2'h0;
	localparam logic [1:0] LVL_ONE = 2'h1;
	localparam logic [1:0] LVL_TWO = 2'h2;
	localparam logic [1:0] LVL_THREE = 2'h3;
	localparam logic [5:0] TRAP_CLASS = 6'h18;
	// Register selectors on the access port
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_CDN = 2'h1;
	localparam logic [1:0] SEL_MISC = 2'h2;
	// Fault generation control fields
	localparam int CTL_EN_BIT = 31;
	localparam int CTL_RESTART_BIT = 30;
	localparam int CTL_CE_LSB = 6;
	localparam int CTL_DE_BIT = 5;
	localparam int CTL_UC_BIT = 1;
	localparam logic [63:0] CTL_WMASK = 64'h0000_0000_C000_00E2;
	localparam logic [63:0] CDN_WMASK = 64'h0000_0000_FFFF_FFFF;
	// Misc syndrome fields; bits 63:48 and 27:26 stay zero
	localparam int OFO_BIT = 47;
	localparam int OTHER_CORRECTED_COUNT_LSB = 40;
	localparam int OFR_BIT = 39;
	localparam int REPEAT_CORRECTED_COUNT_LSB = 32;
	localparam int LOC_LSB = 0;
	localparam logic [63:0] MISC_WMASK = 64'h0000_FFFF_F3FF_FFFF;
	localparam logic [1:0] CE_NONSPECIFIC = 2'h1;
	localparam logic [3:0] UNIT_L1I = 4'h1;
	localparam logic [3:0] UNIT_L1D = 4'h2;
	localparam logic [3:0] UNIT_L2 = 4'h8;
	localparam logic [6:0] CNT_ONE = 7'h01;
	localparam logic [31:0] CDN_ONE = 32'h0000_0001;
	localparam logic [31:0] CDN_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		RFCM_OK,
		RFCM_UNDEF,
		RFCM_TRAP2,
		RFCM_TRAP3
	} rfcm_outcome_type;
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] sel;
		logic [1:0] level;
		logic [63:0] wdata;
	} rfcm_req_type;
	typedef struct packed {
		logic l2_enabled;
		logic hyp_fault_injection_allow;
		logic hyp_error_trap;
		logic sec_fault_injection_allow;
		logic sec_error_trap;
		logic fine_grain_trap_allow;
		logic [2:0] hyp_fine_read_trap;
		logic [2:0] hyp_fine_write_trap;
	} rfcm_trapcfg_type;
	// Syndrome of one detected corrected error
	typedef struct packed {
		logic valid;
		logic [3:0] unit;
		logic [3:0] way;
		logic subbank;
		logic [1:0] bank;
		logic [3:0] subarray;
		logic [12:0] index;
		logic [1:0] array;
	} rfcm_err_type;
	typedef struct packed {
		logic corrected;
		logic deferred;
		logic uncontainable;
	} rfcm_inject_type;
endpackage : rfcm_pkg

// >>> design/rfcm_regs.sv
/*
 * Fault countdown reload, generation control and misc syndrome registers
 * with privilege trap checks. Assumes requests are single-cycle pulses and
 * the error detectors present one syndrome per cycle.
 */
`timescale 1ns/1ps
module rfcm_regs
	import rfcm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire rfcm_req_type req,
	input wire rfcm_trapcfg_type trap_cfg,
	input wire logic count_event,
	input wire rfcm_err_type err,
	output rfcm_outcome_type resp_outcome,
	output logic resp_valid,
	output logic [5:0] resp_class,
	output logic [63:0] resp_rdata,
	output rfcm_inject_type inject,
	output logic status_overflow_disturb
);

////////////////////////////////////////////////////////////////////////////////
// Trap decode

	// Control and countdown gate on injection enables, misc on error traps
	function automatic rfcm_outcome_type check_access(input rfcm_req_type r,
			input rfcm_trapcfg_type c);
		logic is_misc;
		logic fine;
		logic hyp_block;
		logic sec_block;
		is_misc = (r.sel == SEL_MISC);
		fine = r.write ? c.hyp_fine_write_trap[r.sel] : c.hyp_fine_read_trap[r.sel];
		hyp_block = is_misc ? c.hyp_error_trap : !c.hyp_fault_injection_allow;
		sec_block = is_misc ? c.sec_error_trap : !c.sec_fault_injection_allow;
		check_access = RFCM_OK;
		unique case (r.level)
			LVL_ZERO: check_access = RFCM_UNDEF;
			LVL_ONE: begin
				if (c.l2_enabled && hyp_block)
					check_access = RFCM_TRAP2;
				else if (c.l2_enabled && c.fine_grain_trap_allow && fine)
					check_access = RFCM_TRAP2;
				else if (sec_block)
					check_access = RFCM_TRAP3;
			end
			LVL_TWO: begin
				if (sec_block)
					check_access = RFCM_TRAP3;
			end
			LVL_THREE: check_access = RFCM_OK;
		endcase
	endfunction : check_access

	wire rfcm_outcome_type outcome = check_access(req, trap_cfg);
	wire logic granted = req.valid && (outcome == RFCM_OK);
	wire logic wr_ctrl = granted && req.write && (req.sel == SEL_CTRL);
	wire logic wr_cdn = granted && req.write && (req.sel == SEL_CDN);
	wire logic wr_misc = granted && req.write && (req.sel == SEL_MISC);

////////////////////////////////////////////////////////////////////////////////
// Countdown and generation control

	logic [63:0] gen_ctrl;
	logic [31:0] countdown_reload_value;
	logic [31:0] gen_counter;
	logic counting;

	wire logic countdown_enable = gen_ctrl[CTL_EN_BIT];
	wire logic restart = gen_ctrl[CTL_RESTART_BIT];
	wire logic load_now = wr_ctrl && req.wdata[CTL_EN_BIT];
	wire logic hit_zero = counting && count_event && (gen_counter == CDN_ONE);
	wire logic [31:0] next_gen_counter =
		load_now ? countdown_reload_value :
		(hit_zero && restart) ? countdown_reload_value :
		(counting && count_event) ? gen_counter - CDN_ONE : gen_counter;
	wire logic next_counting =
		load_now ? (countdown_reload_value != CDN_ZERO) :
		!countdown_enable ? 1'b0 :
		hit_zero ? restart : counting;
	wire rfcm_inject_type next_inject = '{
		corrected: hit_zero && (gen_ctrl[CTL_CE_LSB +: 2] == CE_NONSPECIFIC),
		deferred: hit_zero && gen_ctrl[CTL_DE_BIT],
		uncontainable: hit_zero && gen_ctrl[CTL_UC_BIT]};

	// Control resets to zero; reload value has no reset at all
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			gen_ctrl <= '0;
			gen_counter <= '0;
			counting <= 1'b0;
			inject <= '0;
		end else begin
			if (wr_ctrl)
				gen_ctrl <= req.wdata & CTL_WMASK;
			gen_counter <= next_gen_counter;
			counting <= next_counting;
			inject <= next_inject;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (wr_cdn)
			countdown_reload_value <= req.wdata[31:0];
	end

////////////////////////////////////////////////////////////////////////////////
// Misc syndrome record

	// No reset: counters and location survive resets, the repeat count is
	// left undefined until software writes it
	logic [63:0] misc_syndrome_reg0;
	logic recorded;

	wire logic [6:0] other_corrected_count = misc_syndrome_reg0[OTHER_CORRECTED_COUNT_LSB +: 7];
	wire logic [6:0] repeat_corrected_count = misc_syndrome_reg0[REPEAT_CORRECTED_COUNT_LSB +: 7];
	// Location spans way down to unit, bits 31:0; reserved 27:26 forced zero
	wire logic [31:0] err_loc = {err.way, 2'b00,
		(err.unit == UNIT_L1I && err.array != 2'b01) ? 1'b0 : err.subbank,
		(err.unit == UNIT_L1I && err.array != 2'b01) ? 2'b00 : err.bank,
		err.subarray, err.index, err.array, err.unit};
	wire logic is_repeat = !recorded ||
		(err_loc == misc_syndrome_reg0[LOC_LSB +: 32]);
	wire logic [6:0] next_repeat_corrected_count = repeat_corrected_count + CNT_ONE;
	wire logic [6:0] next_other_corrected_count = other_corrected_count + CNT_ONE;
	wire logic [63:0] wr_misc_val = req.wdata & MISC_WMASK;

	always_ff @(posedge sys_clk) begin
		if (wr_misc) begin
			misc_syndrome_reg0 <= wr_misc_val;
		end else if (err.valid && is_repeat) begin
			misc_syndrome_reg0[REPEAT_CORRECTED_COUNT_LSB +: 7] <= next_repeat_corrected_count;
			if (next_repeat_corrected_count == 7'h00)
				misc_syndrome_reg0[OFR_BIT] <= 1'b1;
			if (!recorded)
				misc_syndrome_reg0[LOC_LSB +: 32] <= err_loc;
		end else if (err.valid) begin
			misc_syndrome_reg0[OTHER_CORRECTED_COUNT_LSB +: 7] <= next_other_corrected_count;
			if (next_other_corrected_count == 7'h00)
				misc_syndrome_reg0[OFO_BIT] <= 1'b1;
		end
	end

	// Recording marker is cleared by reset or by a software write
	always_ff @(posedge sys_clk) begin
		if (sys_rst || wr_misc)
			recorded <= 1'b0;
		else if (err.valid)
			recorded <= 1'b1;
	end

////////////////////////////////////////////////////////////////////////////////
// Response

	wire logic [63:0] rd_val =
		(req.sel == SEL_CTRL) ? gen_ctrl :
		(req.sel == SEL_CDN) ? {32'h0000_0000, countdown_reload_value} :
		(req.sel == SEL_MISC) ? (misc_syndrome_reg0 & MISC_WMASK) : 64'h0000_0000_0000_0000;
	wire logic flag_change = wr_misc &&
		((wr_misc_val[OFO_BIT] != misc_syndrome_reg0[OFO_BIT]) ||
		(wr_misc_val[OFR_BIT] != misc_syndrome_reg0[OFR_BIT]));

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			resp_valid <= 1'b0;
			resp_outcome <= RFCM_OK;
			resp_class <= '0;
			resp_rdata <= '0;
			status_overflow_disturb <= 1'b0;
		end else begin
			resp_valid <= req.valid;
			resp_outcome <= outcome;
			resp_class <= (outcome == RFCM_TRAP2 || outcome == RFCM_TRAP3) ? TRAP_CLASS : 6'h00;
			resp_rdata <= (granted && !req.write) ? rd_val : 64'h0000_0000_0000_0000;
			status_overflow_disturb <= flag_change;
		end
	end

endmodule : rfcm_regs

// >>> tb/rfcm_regs_bench.sv
/* Bench for rfcm_regs: trap ladder, countdown and syndrome counters.
 * Assumes the package and the checker are compiled first. */
`timescale 1ns/1ps
module rfcm_regs_bench
	import rfcm_pkg::*;
;
// Trap setups: open, hyp injection off, fine read trap on reload, secure injection off
localparam rfcm_trapcfg_type OPEN = 12'hd00;
localparam rfcm_trapcfg_type NOHYP = 12'h900;
localparam rfcm_trapcfg_type FINE = 12'hd50;
localparam rfcm_trapcfg_type NOSEC = 12'hc00;
localparam rfcm_err_type ERR_A = {1'b1, 4'h8, 4'h3, 1'b0, 2'h1, 4'h2, 13'h0055, 2'h1};
localparam rfcm_err_type ERR_B = {1'b1, 4'h2, 4'h1, 1'b0, 2'h0, 4'h1, 13'h0007, 2'h2};
logic sys_clk = 1'b0;
logic sys_rst = 1'b1;
logic count_event = 1'b0;
rfcm_req_type req = '0;
rfcm_trapcfg_type trap_cfg = OPEN;
rfcm_err_type err = '0;
rfcm_outcome_type resp_outcome;
logic resp_valid;
logic [5:0] resp_class;
logic [63:0] resp_rdata;
rfcm_inject_type inject;
logic status_overflow_disturb;
int error_cnt = 0;
int num_checks = 0;
int cyc = 0;
int inj_cnt = 0;
int dist_cnt = 0;
int base;
rfcm_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .trap_cfg(trap_cfg),
	.count_event(count_event), .err(err), .resp_outcome(resp_outcome),
	.resp_valid(resp_valid), .resp_class(resp_class), .resp_rdata(resp_rdata),
	.inject(inject), .status_overflow_disturb(status_overflow_disturb));
initial begin
	forever #25 sys_clk = ~sys_clk;
end
////////////////////////////////////////////////////////////////
task final_report;
	$display("checks=%0d errors=%0d", num_checks, error_cnt);
	if (error_cnt == 0 && num_checks > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask : final_report
task chk(input logic [63:0] seen, input logic [63:0] exp);
	num_checks++;
	if (seen !== exp) begin
		error_cnt++;
		$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask : chk
task acc(input logic w, input logic [1:0] s, input logic [1:0] l, input logic [63:0] d,
	input rfcm_trapcfg_type c, input rfcm_outcome_type o, input logic [63:0] r);
	@(posedge sys_clk);
	req <= {1'b1, w, s, l, d};
	trap_cfg <= c;
	@(posedge sys_clk);
	req.valid <= 1'b0;
	#1;
	chk(resp_valid, 1'b1);
	chk(resp_outcome, o);
	chk(resp_class, (o == RFCM_TRAP2 || o == RFCM_TRAP3) ? TRAP_CLASS : 6'h0);
	chk(resp_rdata, r);
endtask : acc
task hit(input rfcm_err_type e);
	@(posedge sys_clk);
	err <= e;
	@(posedge sys_clk);
	err.valid <= 1'b0;
endtask : hit
task run(input int n, input int exp);
	base = inj_cnt;
	@(posedge sys_clk);
	count_event <= 1'b1;
	repeat (n) @(posedge sys_clk);
	count_event <= 1'b0;
	repeat (3) @(posedge sys_clk);
	chk(inj_cnt - base, exp);
endtask : run
// Registered outputs are sampled at the edge after they settle
always @(posedge sys_clk) begin
	cyc++;
	inj_cnt += (inject === 3'h7);
	dist_cnt += (status_overflow_disturb === 1'b1);
	if (cyc == 3000) begin
		error_cnt++;
		final_report();
	end
end
initial begin
	repeat (12) @(posedge sys_clk);
	sys_rst <= 1'b0;
	acc(1, SEL_CDN, LVL_THREE, 64'hFFFF_FFFF_0000_0003, OPEN, RFCM_OK, 64'h0);
	acc(0, SEL_CDN, LVL_THREE, 64'h0, OPEN, RFCM_OK, 64'h0000_0000_0000_0003);
	acc(1, SEL_CDN, LVL_ZERO, 64'h0000_0000_0000_0009, OPEN, RFCM_UNDEF, 64'h0);
	acc(0, SEL_CTRL, LVL_ONE, 64'h0, NOHYP, RFCM_TRAP2, 64'h0);
	acc(0, SEL_CDN, LVL_ONE, 64'h0, FINE, RFCM_TRAP2, 64'h0);
	acc(1, SEL_CDN, LVL_TWO, 64'h0000_0000_0000_0009, NOSEC, RFCM_TRAP3, 64'h0);
	@(posedge sys_clk) sys_rst <= 1'b1;
	repeat (2) @(posedge sys_clk);
	sys_rst <= 1'b0;
	acc(0, SEL_CDN, LVL_ONE, 64'h0, OPEN, RFCM_OK, 64'h0000_0000_0000_0003);
	$display("test traps done");
	acc(1, SEL_CTRL, LVL_THREE, 64'h0000_0000_C000_0062, OPEN, RFCM_OK, 64'h0);
	run(7, 2);
	acc(0, SEL_CTRL, LVL_THREE, 64'h0, OPEN, RFCM_OK, 64'h0000_0000_C000_0062);
	acc(1, SEL_CTRL, LVL_THREE, 64'h0000_0000_8000_0062, OPEN, RFCM_OK, 64'h0);
	run(7, 1);
	$display("test countdown done");
	acc(1, SEL_MISC, LVL_THREE, 64'h0, OPEN, RFCM_OK, 64'h0);
	hit(ERR_A);
	hit(ERR_A);
	hit(ERR_B);
	acc(0, SEL_MISC, LVL_THREE, 64'h0, OPEN, RFCM_OK, 64'h0000_0102_3090_1558);
	acc(1, SEL_MISC, LVL_THREE, 64'h0000_007F_0000_0000, OPEN, RFCM_OK, 64'h0);
	hit(ERR_A);
	acc(0, SEL_MISC, LVL_THREE, 64'h0, OPEN, RFCM_OK, 64'h0000_0080_3090_1558);
	base = dist_cnt;
	acc(1, SEL_MISC, LVL_THREE, 64'h0000_7F00_0000_0000, OPEN, RFCM_OK, 64'h0);
	hit(ERR_A);
	chk(dist_cnt - base, 1);
	hit(ERR_B);
	acc(0, SEL_MISC, LVL_THREE, 64'h0, OPEN, RFCM_OK, 64'h0000_8001_3090_1558);
	$display("test syndrome done");
	final_report();
end
endmodule : rfcm_regs_bench

// >>> tb/rfcm_regs_properties.sv
/* Port checker for rfcm_regs.
 * Assumes it is bound onto every rfcm_regs instance. */
`timescale 1ns/1ps
module rfcm_regs_properties
	import rfcm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire rfcm_req_type req,
	input wire rfcm_trapcfg_type trap_cfg,
	input wire logic count_event,
	input wire rfcm_err_type err,
	input wire rfcm_outcome_type resp_outcome,
	input wire logic resp_valid,
	input wire logic [5:0] resp_class,
	input wire logic [63:0] resp_rdata,
	input wire rfcm_inject_type inject,
	input wire logic status_overflow_disturb
);
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
// Control and countdown share one trap ladder
wire logic fault_reg = req.valid && !req.sel[1];
////////////////////////////////////////////////////////////////
a_answer_next: assert property (req.valid |=> resp_valid) else $error("no answer");
a_no_stray: assert property (!req.valid |=> !resp_valid) else $error("stray answer");
a_lowest_undef: assert property (fault_reg && req.level == LVL_ZERO
	|=> resp_outcome == RFCM_UNDEF) else $error("level zero not undefined");
a_top_direct: assert property (fault_reg && req.level == LVL_THREE
	|=> resp_outcome == RFCM_OK) else $error("level three refused");
a_hyp_trap: assert property (fault_reg && req.level == LVL_ONE && trap_cfg.l2_enabled
	&& !trap_cfg.hyp_fault_injection_allow |=> resp_outcome == RFCM_TRAP2)
	else $error("missing trap to two");
a_sec_trap: assert property (fault_reg && req.level == LVL_TWO
	&& !trap_cfg.sec_fault_injection_allow |=> resp_outcome == RFCM_TRAP3)
	else $error("missing trap to three");
a_trap_class: assert property (resp_valid && resp_outcome inside {RFCM_TRAP2, RFCM_TRAP3}
	|-> resp_class == TRAP_CLASS) else $error("bad trap class");
a_cdn_upper: assert property (resp_valid && $past(req.sel) == SEL_CDN
	|-> resp_rdata[63:32] == 32'h0) else $error("reload upper bits set");
a_misc_reserved: assert property (resp_valid && $past(req.sel) == SEL_MISC
	|-> resp_rdata[63:48] == 16'h0 && resp_rdata[27:26] == 2'h0) else $error("misc reserved set");
a_inject_cause: assert property (inject != 3'h0 |-> $past(count_event))
	else $error("inject without event");
c_inject: cover property (inject.corrected);
c_trap3: cover property (resp_valid && resp_outcome == RFCM_TRAP3);
c_disturb: cover property (status_overflow_disturb);
endmodule : rfcm_regs_properties
bind rfcm_regs rfcm_regs_properties chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
	.trap_cfg(trap_cfg), .count_event(count_event), .err(err), .resp_outcome(resp_outcome),
	.resp_valid(resp_valid), .resp_class(resp_class), .resp_rdata(resp_rdata),
	.inject(inject), .status_overflow_disturb(status_overflow_disturb));
